/* core/pwr_ctl.sv */
// Reduced power mode controller: idle, power-down, wake and watchdog key.
// Assumes an AXI4-Lite master and a core that honours the clock enables.
`timescale 1ns/1ps
`default_nettype none
`include "pwr_ctl_consts.svh"

module pwr_ctl #(
   parameter int SETTLE_CYCLES = (`PC_SETTLE_NS + `PC_CLK_NS - 1) / `PC_CLK_NS
) (
   input  wire logic                REF_CLK,     // System clock, 100 MHz
   input  wire logic                RST,         // Sync reset, active high
   input  wire logic [11:0]         AWADDR,      // Write address
   input  wire logic                AWVALID,     // Write address valid
   output logic                     AWREADY,     // Write address ready
   input  wire logic [31:0]         WDATA,       // Write data
   input  wire logic [3:0]          WSTRB,       // Write byte strobes
   input  wire logic                WVALID,      // Write data valid
   output logic                     WREADY,      // Write data ready
   output logic [1:0]               BRESP,       // Write response
   output logic                     BVALID,      // Write response valid
   input  wire logic                BREADY,      // Write response ready
   input  wire logic [11:0]         ARADDR,      // Read address
   input  wire logic                ARVALID,     // Read address valid
   output logic                     ARREADY,     // Read address ready
   output logic [31:0]              RDATA,       // Read data
   output logic [1:0]               RRESP,       // Read response
   output logic                     RVALID,      // Read data valid
   input  wire logic                RREADY,      // Read data ready
   input  wire logic                IRQ_ENABLED, // Enabled interrupt pending
   input  wire logic                EXT_IRQ,     // Level external interrupt
   input  wire logic                ADC_CMP_IRQ, // Software ADC compare hit
   output logic                     OSC_RUN,     // Crystal oscillator enable
   output logic                     CPU_CLK_EN,  // CPU clock gate
   output logic                     ACQ_CLK_EN,  // Acquisition clock gate
   output logic                     DISP_CLK_EN, // Display clock gate
   output logic                     PERIPH_CLK_EN, // Memory, bus, timers, PWM
   output logic                     WD_ACTIVE,   // Watchdog running
   output logic [7:0]               WD_PERIOD,   // Watchdog period field
   output logic                     WAKE_IRQ,    // Wake interrupt to service
   output logic                     RESET_INIT,  // Init registers, display RAM
   output logic                     AUX_LOST     // Aux/display RAM not kept
);
   import pwr_ctl_pkg::*;

   localparam logic [15:0] SETTLE_LAST = 16'(SETTLE_CYCLES - 1);

   typedef struct packed {
      mode_type    mode;
      logic        idle_bit;
      logic        down_bit;
      logic        adc_cmp_en;
      logic [7:0]  wd_period;
      logic [7:0]  wd_key;
      logic        wd_active;
      logic [15:0] settle_cnt;
      logic        wake_irq;
      logic        aux_lost;
      logic        aw_hold;
      logic        w_hold;
      logic [11:0] aw_addr;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic        bvalid;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic [1:0]  bresp;
   } state_type;

   state_type state_reg;
   state_type state_next;

   // Word read decode, shared by read path and write mapping check
   function automatic logic mapped(input logic [11:0] a);
      return a == `PC_OFF_POWER_CTL || a == `PC_OFF_WD_PERIOD ||
             a == `PC_OFF_WD_KEY || a == `PC_OFF_STATUS;
   endfunction

   logic wake_src;

   // Next-state logic: bus slave, mode machine and watchdog key
   always_comb begin
      state_next = state_reg;
      // Compare wake only counts when the compare mode is armed
      wake_src = EXT_IRQ || IRQ_ENABLED ||
                 (state_reg.adc_cmp_en && ADC_CMP_IRQ);

      // Bus capture, address and data in either order
      if (AWVALID && !state_reg.aw_hold) begin
         state_next.aw_hold = 1'b1;
         state_next.aw_addr = AWADDR;
      end
      if (WVALID && !state_reg.w_hold) begin
         state_next.w_hold = 1'b1;
         state_next.w_data = WDATA;
         state_next.w_strb = WSTRB;
      end
      if (state_reg.bvalid && BREADY) begin
         state_next.bvalid = 1'b0;
      end
      if (state_reg.rvalid && RREADY) begin
         state_next.rvalid = 1'b0;
      end
      if (state_reg.wake_irq) begin
         state_next.wake_irq = 1'b0;
      end

      // Register write once both halves are held
      if (state_reg.aw_hold && state_reg.w_hold && !state_reg.bvalid) begin
         state_next.aw_hold = 1'b0;
         state_next.w_hold  = 1'b0;
         state_next.bvalid  = 1'b1;
         state_next.bresp   = mapped(state_reg.aw_addr) ? 2'b00 : 2'b10;
         if (state_reg.w_strb[0]) begin
            case (state_reg.aw_addr)
               `PC_OFF_POWER_CTL: begin
                  state_next.idle_bit   = state_reg.w_data[`PC_BIT_IDLE];
                  state_next.down_bit   =
                     state_reg.w_data[`PC_BIT_POWERDOWN];
                  state_next.adc_cmp_en =
                     state_reg.w_data[`PC_BIT_ADC_CMP_EN];
               end
               `PC_OFF_WD_PERIOD: begin
                  state_next.wd_period = state_reg.w_data[7:0];
                  state_next.wd_active = 1'b1;
               end
               `PC_OFF_WD_KEY: begin
                  state_next.wd_key = state_reg.w_data[7:0];
                  if (state_reg.wd_active &&
                      state_reg.w_data[7:0] == `PC_WD_KEY_DISABLE) begin
                     state_next.wd_active = 1'b0;
                  end
               end
               default: begin
               end
            endcase
         end
      end

      // Register read, one at a time
      if (ARVALID && !state_reg.rvalid) begin
         state_next.rvalid = 1'b1;
         state_next.rresp  = mapped(ARADDR) ? 2'b00 : 2'b10;
         case (ARADDR)
            `PC_OFF_POWER_CTL:
               state_next.rdata = {29'h0000_0000, state_reg.adc_cmp_en,
                                   state_reg.down_bit, state_reg.idle_bit};
            `PC_OFF_WD_PERIOD:
               state_next.rdata = {24'h00_0000, state_reg.wd_period};
            `PC_OFF_WD_KEY:
               state_next.rdata = {24'h00_0000, state_reg.wd_key};
            `PC_OFF_STATUS:
               state_next.rdata = {27'h000_0000, state_reg.aux_lost,
                                   state_reg.wd_active, 1'b0,
                                   2'(state_reg.mode)};
            default:
               state_next.rdata = 32'h0000_0000;
         endcase
      end

      // Mode machine; request bits take effect once the write lands
      case (state_reg.mode)
         RUN_STATE: begin
            if (state_reg.down_bit) begin
               state_next.mode     = DOWN_STATE;
               state_next.aux_lost = 1'b1;
            end else if (state_reg.idle_bit) begin
               state_next.mode = IDLE_STATE;
            end
         end
         IDLE_STATE: begin
            // Wake clears the request bit by hardware
            if (wake_src) begin
               state_next.idle_bit = 1'b0;
               state_next.mode     = RUN_STATE;
               state_next.wake_irq = 1'b1;
            end
         end
         DOWN_STATE: begin
            // Only level sources can wake; no clocked edge detect here
            if (EXT_IRQ || (state_reg.adc_cmp_en && ADC_CMP_IRQ)) begin
               state_next.mode       = SETTLE_STATE;
               state_next.settle_cnt = 16'h0000;
            end
         end
         SETTLE_STATE: begin
            // Oscillator restarted, CPU held until it is stable
            if (state_reg.settle_cnt == SETTLE_LAST) begin
               state_next.mode     = RUN_STATE;
               state_next.down_bit = 1'b0;
               state_next.wake_irq = 1'b1;
            end else begin
               state_next.settle_cnt = state_reg.settle_cnt + 16'h0001;
            end
         end
         default: begin
            state_next.mode = RUN_STATE;
         end
      endcase
   end

   // Reset also ends either low power mode and reinitialises registers
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         state_reg            <= '0;
         state_reg.mode       <= RUN_STATE;
         state_reg.wd_period  <= `PC_WD_PERIOD_RST;
         state_reg.wd_key     <= `PC_WD_KEY_RST;
      end else begin
         state_reg <= state_next;
      end
   end

   // Bus handshakes
   assign AWREADY = !state_reg.aw_hold;
   assign WREADY  = !state_reg.w_hold;
   assign BVALID  = state_reg.bvalid;
   assign BRESP   = state_reg.bresp;
   assign ARREADY = !state_reg.rvalid;
   assign RVALID  = state_reg.rvalid;
   assign RDATA   = state_reg.rdata;
   assign RRESP   = state_reg.rresp;

   // Clock gates; registers and pins simply hold while gated
   assign OSC_RUN       = state_reg.mode != DOWN_STATE;
   assign CPU_CLK_EN    = state_reg.mode == RUN_STATE;
   assign ACQ_CLK_EN    = state_reg.mode == RUN_STATE;
   assign DISP_CLK_EN   = state_reg.mode == RUN_STATE;
   assign PERIPH_CLK_EN = state_reg.mode != DOWN_STATE;
   assign WD_ACTIVE     = state_reg.wd_active;
   assign WD_PERIOD     = state_reg.wd_period;
   assign WAKE_IRQ      = state_reg.wake_irq;
   assign RESET_INIT    = RST;
   assign AUX_LOST      = state_reg.aux_lost;

   // Idle holds CPU gated until a wake source appears
   property p_idle_gates;
      @(posedge REF_CLK) disable iff (RST)
         state_reg.mode == IDLE_STATE |-> !CPU_CLK_EN && OSC_RUN;
   endproperty
   a_idle_gates: assert property (p_idle_gates)
      else $error("CPU clock runs in idle");

   property p_periph_idle;
      @(posedge REF_CLK) disable iff (RST)
         state_reg.mode == IDLE_STATE |-> PERIPH_CLK_EN;
   endproperty
   a_periph_idle: assert property (p_periph_idle)
      else $error("Peripheral clock lost in idle");

   property p_idle_wake;
      @(posedge REF_CLK) disable iff (RST)
         state_reg.mode == IDLE_STATE && IRQ_ENABLED |=>
            CPU_CLK_EN && WAKE_IRQ && !state_reg.idle_bit;
   endproperty
   a_idle_wake: assert property (p_idle_wake)
      else $error("Idle not ended by interrupt");

   property p_adc_wake;
      @(posedge REF_CLK) disable iff (RST)
         state_reg.mode == IDLE_STATE && state_reg.adc_cmp_en &&
         ADC_CMP_IRQ |=> state_reg.mode == RUN_STATE;
   endproperty
   a_adc_wake: assert property (p_adc_wake)
      else $error("Compare did not end idle");

   property p_down_osc;
      @(posedge REF_CLK) disable iff (RST)
         state_reg.mode == RUN_STATE && state_reg.down_bit |=>
            !OSC_RUN && AUX_LOST;
   endproperty
   a_down_osc: assert property (p_down_osc)
      else $error("Oscillator not stopped");

   sequence s_settle;
      (!CPU_CLK_EN && OSC_RUN) [*8];
   endsequence
   property p_settle;
      @(posedge REF_CLK) disable iff (RST)
         state_reg.mode == DOWN_STATE && EXT_IRQ |=> s_settle;
   endproperty
   a_settle: assert property (p_settle)
      else $error("CPU released before settling");

   property p_key;
      @(posedge REF_CLK) disable iff (RST)
         state_reg.aw_hold && state_reg.w_hold && !state_reg.bvalid &&
         state_reg.aw_addr == `PC_OFF_WD_KEY && state_reg.w_strb[0] &&
         state_reg.w_data[7:0] == `PC_WD_KEY_DISABLE |=> !WD_ACTIVE;
   endproperty
   a_key: assert property (p_key)
      else $error("Key did not disable watchdog");

   property p_reset;
      @(posedge REF_CLK) RST |=> CPU_CLK_EN && !state_reg.idle_bit &&
         !state_reg.down_bit;
   endproperty
   a_reset: assert property (p_reset)
      else $error("Reset did not end low power");

   // Wake interrupt is one cycle long so the core services it once
   property p_wake_pulse;
      @(posedge REF_CLK) disable iff (RST)
         WAKE_IRQ |=> !WAKE_IRQ;
   endproperty
   a_wake_pulse: assert property (p_wake_pulse)
      else $error("Wake pulse longer than one cycle");

   // Lost aux contents stay flagged until the next reset
   property p_aux_keep;
      @(posedge REF_CLK) disable iff (RST)
         AUX_LOST |=> AUX_LOST;
   endproperty
   a_aux_keep: assert property (p_aux_keep)
      else $error("Aux lost flag cleared without reset");

   // Armed compare ends power-down through the settle wait
   property p_down_cmp;
      @(posedge REF_CLK) disable iff (RST)
         state_reg.mode == DOWN_STATE && state_reg.adc_cmp_en &&
         ADC_CMP_IRQ |=> state_reg.mode == SETTLE_STATE && OSC_RUN;
   endproperty
   a_down_cmp: assert property (p_down_cmp)
      else $error("Compare did not end power-down");

   // Acquisition and display are gated together with the CPU
   property p_idle_side;
      @(posedge REF_CLK) disable iff (RST)
         state_reg.mode == IDLE_STATE |-> !ACQ_CLK_EN && !DISP_CLK_EN;
   endproperty
   a_idle_side: assert property (p_idle_side)
      else $error("Acquisition or display clock runs in idle");

   // Write answer holds until the master takes it
   property p_bresp_hold;
      @(posedge REF_CLK) disable iff (RST)
         BVALID && !BREADY |=> BVALID && $stable(BRESP);
   endproperty
   a_bresp_hold: assert property (p_bresp_hold)
      else $error("Write response dropped early");

   // Read answer holds until the master takes it
   property p_rdata_hold;
      @(posedge REF_CLK) disable iff (RST)
         RVALID && !RREADY |=> RVALID && $stable(RDATA) && $stable(RRESP);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold)
      else $error("Read data dropped early");
endmodule

`default_nettype wire

/* core/pwr_ctl_consts.svh */
// Constants for the reduced power mode controller: offsets, fields, resets.
// Assumes inclusion by the controller and the bench, 100 MHz REF_CLK.
// Summary of operation
// - Setting the idle request bit gates the CPU, acquisition and display clocks; the oscillator keeps running.
// - In idle the memory, two-wire bus, timer, watchdog and modulator clocks keep running.
// - In idle CPU state, register, RAM and pin values are frozen in place.
// - An enabled interrupt in idle clears the idle bit, restarts the clocks and is serviced.
// - A software ADC compare interrupt, when that mode is set, also ends idle.
// - An external reset ends idle and needs to be held only two machine cycles.
// - Reset initialises registers and display memory, keeps other RAM, and starts at address zero.
// - Setting the power-down request bit stops the crystal oscillator.
// - In power-down registers, data memory and pins are kept; auxiliary and display memory are lost.
// - An external or software ADC compare interrupt ends power-down and is serviced.
// - An external reset also ends power-down with full initialisation from address zero.
// - The watchdog has an 8-bit period and an 8-bit key; key 55H disables it while active.
`ifndef PWR_CTL_CONSTS_SVH
`define PWR_CTL_CONSTS_SVH

`define PC_OFF_POWER_CTL   12'h000
`define PC_OFF_WD_PERIOD   12'h004
`define PC_OFF_WD_KEY      12'h008
`define PC_OFF_STATUS      12'h00C

`define PC_BIT_IDLE        0
`define PC_BIT_POWERDOWN   1
`define PC_BIT_ADC_CMP_EN  2

`define PC_WD_KEY_DISABLE  8'h55
`define PC_WD_PERIOD_RST   8'h00
`define PC_WD_KEY_RST      8'h00

`define PC_SETTLE_NS       1000
`define PC_CLK_NS          10
`define PC_RESET_CYCLES    24

`endif

/* core/pwr_ctl_pkg.sv */
// Types shared by the reduced power mode controller.
// Assumes the constants header is found on the include path.
package pwr_ctl_pkg;
   typedef enum logic [1:0] {
      RUN_STATE,
      IDLE_STATE,
      DOWN_STATE,
      SETTLE_STATE
   } mode_type;
endpackage

/* verification/reduced_power_mode_control_tb.sv */
// Self-checking bench for the reduced power mode controller.
// Assumes the core files compiled first; bench acts as AXI4-Lite master.
`timescale 1ns/1ps
`default_nettype none
`include "pwr_ctl_consts.svh"

module reduced_power_mode_control_tb;
   localparam int SETTLE = 20; // Short settle keeps the run brief
   logic        ref_clk = 0, rst = 1, irq_en = 0, ext_irq = 0, adc_irq = 0;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [11:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata, d;
   logic [3:0]  wstrb = 0;
   logic [1:0]  bresp, rresp, r;
   logic        awready, wready, bvalid, arready, rvalid, osc, cpu, acq;
   logic        disp, per, wd_act, wake, rst_init, aux;
   logic [7:0]  wd_per;
   int          mismatches = 0, total_checks = 0, n;

   pwr_ctl #(.SETTLE_CYCLES(SETTLE)) i_dut (
      .REF_CLK(ref_clk), .RST(rst), .AWADDR(awaddr), .AWVALID(awvalid),
      .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid),
      .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
      .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
      .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
      .IRQ_ENABLED(irq_en), .EXT_IRQ(ext_irq), .ADC_CMP_IRQ(adc_irq),
      .OSC_RUN(osc), .CPU_CLK_EN(cpu), .ACQ_CLK_EN(acq),
      .DISP_CLK_EN(disp), .PERIPH_CLK_EN(per), .WD_ACTIVE(wd_act),
      .WD_PERIOD(wd_per), .WAKE_IRQ(wake), .RESET_INIT(rst_init),
      .AUX_LOST(aux));

   // 100 MHz reference
   always #5 ref_clk = ~ref_clk;

   // Compare and count
   task automatic check(input string name, input logic [31:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // Handshakes judged at the rising edge; each channel released once taken
   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      logic aw_t, w_t;
      @(posedge ref_clk);
      aw_t = 0;
      w_t = 0;
      awaddr <= a;
      wdata <= v;
      wstrb <= 4'hF;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      do begin
         @(posedge ref_clk);
         if (!aw_t && awready === 1'b1) begin
            aw_t = 1;
            awvalid <= 0;
         end
         if (!w_t && wready === 1'b1) begin
            w_t = 1;
            wvalid <= 0;
         end
      end while (!(aw_t && w_t));
      do @(posedge ref_clk); while (bvalid !== 1'b1);
      r = bresp;
      bready <= 0;
   endtask

   task automatic rd(input logic [11:0] a);
      @(posedge ref_clk);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      do @(posedge ref_clk); while (arready !== 1'b1);
      arvalid <= 0;
      do @(posedge ref_clk); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 0;
   endtask

   task automatic do_reset(input int cycles);
      @(posedge ref_clk);
      rst <= 1;
      repeat (cycles) @(posedge ref_clk);
      check("reset init", rst_init, 1);
      rst <= 0;
   endtask

   // Counts cycles until the wake pulse, bounded
   task automatic wait_wake();
      n = 0;
      while (wake !== 1'b1 && n < 400) begin
         @(posedge ref_clk);
         n++;
      end
   endtask

   // Hang guard, well beyond the few hundred cycles the tests take
   initial begin
      #200000;
      mismatches++;
      print_verdict();
   end

   initial begin
      do_reset(16);
      check("run gates", {osc, cpu, acq, disp, per, wd_act}, 6'b111110);
      rd(`PC_OFF_WD_PERIOD); check("period rst", d, 0);
      rd(`PC_OFF_STATUS); check("status rst", d, 0);
      rd(12'h010); check("unmapped resp", r, 2'b10);
      check("unmapped data", d, 0);
      // Watchdog period, wrong key, then disabling key
      wr(`PC_OFF_WD_PERIOD, 32'h0000_003C);
      check("wd on", {wd_act, wd_per}, 9'h13C);
      check("wr resp", r, 2'b00);
      wr(12'h010, 32'h0000_00FF);
      check("unmapped wr", r, 2'b10);
      check("unmapped kept", wd_per, 8'h3C);
      rd(`PC_OFF_WD_PERIOD); check("period rd", d, 32'h0000_003C);
      wr(`PC_OFF_WD_KEY, 32'h0000_0012); check("wrong key", wd_act, 1);
      wr(`PC_OFF_WD_KEY, `PC_WD_KEY_DISABLE);
      check("key off", wd_act, 0);
      // Idle, woken by an enabled interrupt; display output taken as off
      wr(`PC_OFF_POWER_CTL, 32'h0000_0001);
      @(posedge ref_clk);
      check("idle gates", {osc, cpu, acq, disp, per}, 5'b10001);
      check("idle frozen", wd_per, 8'h3C);
      rd(`PC_OFF_STATUS); check("idle status", d, 1);
      irq_en <= 1;
      wait_wake(); check("idle wake", {wake, cpu}, 2'b11);
      @(posedge ref_clk);
      check("wake pulse", wake, 0);
      irq_en <= 0;
      rd(`PC_OFF_POWER_CTL); check("idle bit", d[0], 0);
      // Compare hit without its enable must not wake; reset ends idle
      wr(`PC_OFF_POWER_CTL, 32'h0000_0001);
      adc_irq <= 1;
      repeat (5) @(posedge ref_clk);
      check("cmp disarmed", cpu, 0);
      adc_irq <= 0;
      do_reset(`PC_RESET_CYCLES);
      check("reset idle", {cpu, wd_per}, 9'h100);
      rd(`PC_OFF_STATUS); check("reset status", d, 0);
      // Idle with compare wake armed
      wr(`PC_OFF_POWER_CTL, 32'h0000_0005);
      adc_irq <= 1;
      wait_wake(); check("cmp wake", {wake, cpu}, 2'b11);
      adc_irq <= 0;
      // Power-down; only external or armed compare wakes it
      wr(`PC_OFF_POWER_CTL, 32'h0000_0002);
      @(posedge ref_clk);
      check("down gates", {osc, cpu, acq, disp, per, aux}, 6'b000001);
      irq_en <= 1;
      repeat (5) @(posedge ref_clk);
      check("down stays", osc, 0);
      irq_en <= 0;
      ext_irq <= 1;
      wait_wake(); check("ext wake", {wake, cpu, osc}, 3'b111);
      check("settled", n >= SETTLE, 1);
      ext_irq <= 0;
      rd(`PC_OFF_POWER_CTL); check("down bit", d[1], 0);
      rd(`PC_OFF_STATUS); check("aux lost", d, 32'h0000_0010);
      wr(`PC_OFF_POWER_CTL, 32'h0000_0006);
      adc_irq <= 1;
      wait_wake(); check("down cmp", {wake, cpu}, 2'b11);
      check("cmp settled", n >= SETTLE, 1);
      adc_irq <= 0;
      // Reset out of power-down
      wr(`PC_OFF_POWER_CTL, 32'h0000_0002);
      do_reset(`PC_RESET_CYCLES);
      check("reset down", {osc, cpu, aux}, 3'b110);
      rd(`PC_OFF_STATUS); check("down rst st", d, 0);
      print_verdict();
   end
endmodule

`default_nettype wire
